// [common/acrc_defs.vh]
`ifndef ACRC_DEFS_VH
`define ACRC_DEFS_VH
// register addresses
`define ACRC_ADDR_CHAN     13'h001
`define ACRC_ADDR_RATE     13'h002
// reset values
`define ACRC_CHAN_RESET    8'h4f
`define ACRC_RATE_RESET    8'h00
// field positions
`define ACRC_IND_BIT       7
`define ACRC_NCH_MSB       5
`define ACRC_NCH_LSB       3
`define ACRC_DRATE_MSB     7
`define ACRC_DRATE_LSB     4
`define ACRC_CRATE_MSB     3
`define ACRC_CRATE_LSB     0
// rate code encodings
`define ACRC_CODE_ZERO_HI  4'hf
`define ACRC_CODE_ZERO_LO  4'hd
`define ACRC_CODE_OFF_HI   4'he
`define ACRC_CODE_OFF_LO   4'ha
`define ACRC_CODE_FULL     4'hf
`define ACRC_CODE_DIV_MAX  4'h9
// serial frame sizes and sample data width
`define ACRC_HDR_BITS      5'h10
`define ACRC_FRAME_BITS    5'h18
`define ACRC_DATA_W        12
`endif

// [verilog/acrc_spi.v]
`timescale 1ns/1ns
`include "acrc_defs.vh"
module acrc_spi (
  // clock, reset, enable
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        ce_in,
  // serial pins
  input  wire        cs_n_in,
  input  wire        sclk_in,
  input  wire        sdi_in,
  output wire        sdo_out,
  output wire        sdo_oe_out,
  // register side
  output wire [12:0] addr_out,
  output reg         wr_out,
  output wire [7:0]  wdata_out,
  input  wire [7:0]  rdata_in
);
  reg  [4:0]  cnt_q;
  reg  [15:0] hdr_q;
  reg  [7:0]  dat_q;
  reg  [7:0]  sout_q;
  reg         sclk_q;
  wire        rise;
  wire        fall;
  wire        is_read;

  assign rise       = sclk_in & ~sclk_q;
  assign fall       = ~sclk_in & sclk_q;
  assign is_read    = hdr_q[15];
  assign addr_out   = hdr_q[12:0];
  assign wdata_out  = dat_q;
  assign sdo_out    = sout_q[7];
  assign sdo_oe_out = ~cs_n_in & is_read & (cnt_q >= `ACRC_HDR_BITS);

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_q  <= 5'h00;
      hdr_q  <= 16'h0000;
      dat_q  <= 8'h00;
      sout_q <= 8'h00;
      sclk_q <= 1'b0;
      wr_out <= 1'b0;
    end else if (ce_in) begin
      sclk_q <= sclk_in;
      wr_out <= 1'b0;
      if (cs_n_in) begin
        cnt_q <= 5'h00;
      end else if (rise && cnt_q < `ACRC_FRAME_BITS) begin
        cnt_q <= cnt_q + 5'h01;
        if (cnt_q < `ACRC_HDR_BITS) begin
          hdr_q <= {hdr_q[14:0], sdi_in};
        end else begin
          dat_q <= {dat_q[6:0], sdi_in};
        end
        if (cnt_q == `ACRC_HDR_BITS - 5'h01 && sdi_in == 1'b0 && hdr_q[14]) begin
          sout_q <= 8'h00;
        end
        if (cnt_q == `ACRC_FRAME_BITS - 5'h01 && !is_read) begin
          wr_out <= 1'b1;
        end
      end else if (fall && cnt_q == `ACRC_HDR_BITS && is_read) begin
        sout_q <= rdata_in;
      end else if (fall && cnt_q > `ACRC_HDR_BITS) begin
        sout_q <= {sout_q[6:0], 1'b0};
      end
    end
  end
endmodule

// [verilog/acrc_ctrl.v]
`timescale 1ns/1ns
`include "acrc_defs.vh"
module acrc_ctrl (
  // clock, reset, enable
  input  wire        CLK_IN,
  input  wire        RST_N_IN,
  input  wire        CE_IN,
  // serial configuration port
  input  wire        CS_N_IN,
  input  wire        SCLK_IN,
  input  wire        SDI_IN,
  output wire        SDO_OUT,
  output wire        SDO_OE_OUT,
  // converted samples
  input  wire [11:0] SAMPLE_IN,
  input  wire        SAMPLE_VALID_IN,
  // output data
  output reg  [11:0] DATA_OUT,
  output reg         DATA_VALID_OUT,
  output reg  [2:0]  CHANNEL_SEL_OUT,
  // output clock pin pair
  output wire        OCLK_P_OUT,
  output wire        OCLK_N_OUT,
  output wire        OCLK_OE_OUT
);
  wire [12:0] addr;
  wire        wr;
  wire [7:0]  wdata;
  reg  [7:0]  rdata;
  reg  [7:0]  chan_q;
  reg  [7:0]  rate_q;
  reg  [3:0]  dcnt_q;
  reg  [3:0]  ccnt_q;
  reg         oclk_q;
  wire [3:0]  data_code;
  wire [3:0]  clk_code;
  wire [2:0]  nch;
  wire [2:0]  chan_last;
  wire        data_zero;
  wire        clk_off;
  wire [3:0]  ddiv;
  wire [3:0]  cdiv;

  acrc_spi u_spi (
    .clk_in     (CLK_IN),
    .rst_n_in   (RST_N_IN),
    .ce_in      (CE_IN),
    .cs_n_in    (CS_N_IN),
    .sclk_in    (SCLK_IN),
    .sdi_in     (SDI_IN),
    .sdo_out    (SDO_OUT),
    .sdo_oe_out (SDO_OE_OUT),
    .addr_out   (addr),
    .wr_out     (wr),
    .wdata_out  (wdata),
    .rdata_in   (rdata)
  );

  // divisor per rate code: full speed or code+1
  function [3:0] rate_div;
    input [3:0] code;
    begin
      if (code == `ACRC_CODE_FULL || code > `ACRC_CODE_DIV_MAX) begin
        rate_div = 4'h1;
      end else begin
        rate_div = code + 4'h1;
      end
    end
  endfunction

  assign data_code = rate_q[`ACRC_DRATE_MSB:`ACRC_DRATE_LSB];
  // clock code only counts when independent, else follows data
  assign clk_code  = chan_q[`ACRC_IND_BIT] ? rate_q[`ACRC_CRATE_MSB:`ACRC_CRATE_LSB]
                                           : data_code;
  assign nch       = chan_q[`ACRC_NCH_MSB:`ACRC_NCH_LSB];
  assign chan_last = nch - 3'h1; // 000 wraps to 111, eight inputs
  assign data_zero = data_code >= `ACRC_CODE_ZERO_LO;
  assign clk_off   = clk_code >= `ACRC_CODE_OFF_LO && clk_code <= `ACRC_CODE_OFF_HI;
  assign ddiv      = rate_div(data_code);
  assign cdiv      = rate_div(clk_code);

  // register read mux, unmapped reads zero
  always @* begin
    case (addr)
      `ACRC_ADDR_CHAN: rdata = chan_q;
      `ACRC_ADDR_RATE: rdata = rate_q;
      default:         rdata = 8'h00;
    endcase
  end

  // user registers, factory bits written as given
  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      chan_q <= `ACRC_CHAN_RESET;
      rate_q <= `ACRC_RATE_RESET;
    end else if (CE_IN && wr) begin
      if (addr == `ACRC_ADDR_CHAN) begin
        chan_q <= wdata;
      end
      if (addr == `ACRC_ADDR_RATE) begin
        rate_q <= wdata;
      end
    end
  end

  // sample path: channel sequencing and data rate decimation
  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      DATA_OUT        <= 12'h000;
      DATA_VALID_OUT  <= 1'b0;
      CHANNEL_SEL_OUT <= 3'h0;
      dcnt_q          <= 4'h0;
    end else if (CE_IN) begin
      DATA_VALID_OUT <= 1'b0;
      if (SAMPLE_VALID_IN) begin
        CHANNEL_SEL_OUT <= (CHANNEL_SEL_OUT >= chan_last) ? 3'h0
                                                          : CHANNEL_SEL_OUT + 3'h1;
        if (dcnt_q >= ddiv - 4'h1) begin
          dcnt_q         <= 4'h0;
          DATA_VALID_OUT <= 1'b1;
          DATA_OUT       <= data_zero ? 12'h000 : SAMPLE_IN;
        end else begin
          dcnt_q <= dcnt_q + 4'h1;
        end
      end
    end
  end

  // output clock divider
  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      ccnt_q <= 4'h0;
      oclk_q <= 1'b0;
    end else if (CE_IN) begin
      if (ccnt_q >= cdiv - 4'h1) begin
        ccnt_q <= 4'h0;
        oclk_q <= ~oclk_q;
      end else begin
        ccnt_q <= ccnt_q + 4'h1;
      end
    end
  end

  // pin pair silent while clock is off
  assign OCLK_OE_OUT = ~clk_off;
  assign OCLK_P_OUT  = oclk_q & ~clk_off;
  assign OCLK_N_OUT  = ~oclk_q & ~clk_off;
endmodule

// [tb/acrc_host.sv]
`timescale 1ns/1ns
module acrc_host (
  // serial pins
  input  wire clk_in,
  input  wire sdo_in,
  output reg  cs_n_out = 1'b1,
  output reg  sclk_out = 1'b0,
  output reg  sdi_out = 1'b0
);
  // header then data, msb first; no test codes, factory bits kept
  task xfer(input [23:0] f, output [7:0] q);
    integer i;
    begin
      @(posedge clk_in);
      cs_n_out <= 1'b0;
      for (i = 23; i >= 0; i = i - 1) begin
        sdi_out <= f[i];
        repeat (3) @(posedge clk_in);
        q = {q[6:0], sdo_in};
        sclk_out <= 1'b1;
        repeat (3) @(posedge clk_in);
        sclk_out <= 1'b0;
      end
      repeat (3) @(posedge clk_in);
      cs_n_out <= 1'b1;
      sdi_out <= ~sdi_out;
      repeat (2) @(posedge clk_in);
    end
  endtask
endmodule

// [tb/acrc_ctrl_chk.sv]
`timescale 1ns/1ns
module acrc_ctrl_chk (
  // watched ports
  input wire       CLK_IN,
  input wire       RST_N_IN,
  input wire       SAMPLE_VALID_IN,
  input wire       DATA_VALID_OUT,
  input wire [2:0] CHANNEL_SEL_OUT,
  input wire       OCLK_P_OUT,
  input wire       OCLK_N_OUT,
  input wire       OCLK_OE_OUT
);
  default clocking @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  clk_pair_a: assert property (OCLK_OE_OUT |-> OCLK_P_OUT != OCLK_N_OUT)
    else $error("clock pair not complementary");
  clk_off_a: assert property (!OCLK_OE_OUT |-> !OCLK_P_OUT && !OCLK_N_OUT)
    else $error("stopped clock pair not low");
  clk_runs_a: assert property (OCLK_OE_OUT |-> ##[1:24] ($changed(OCLK_P_OUT) || !OCLK_OE_OUT))
    else $error("output clock not toggling");
  valid_cause_a: assert property (DATA_VALID_OUT |-> $past(SAMPLE_VALID_IN))
    else $error("data valid without sample");
  chan_hold_a: assert property ($changed(CHANNEL_SEL_OUT) |-> $past(SAMPLE_VALID_IN))
    else $error("channel moved without sample");
  chan_step_a: assert property ($changed(CHANNEL_SEL_OUT) |->
    CHANNEL_SEL_OUT == $past(CHANNEL_SEL_OUT) + 3'h1 || CHANNEL_SEL_OUT == 3'h0)
    else $error("channel step wrong");
endmodule
bind acrc_ctrl acrc_ctrl_chk u_chk (.*);

// [tb/acrc_ctrl_tb.sv]
`timescale 1ns/1ns
module acrc_ctrl_tb;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [11:0] smp = 12'h000;
  reg         smp_v = 1'b0;
  wire        sdo, cs_n, sclk, sdi, dv, ocp, ocn, oce;
  wire        soe;
  wire        sdo_line;
  reg         ce = 1'b1;
  wire [11:0] dout;
  wire [2:0]  chs;
  reg  [7:0]  q;
  reg  [3:0]  d;
  integer     err_count = 0;
  integer     compares = 0;
  integer     i, k;
  always #5 clk = ~clk;
  // undriven sdo line shows the inverse, so a missing enable corrupts reads
  assign sdo_line = soe ? sdo : ~sdo;
  acrc_host host (.clk_in(clk), .sdo_in(sdo_line), .cs_n_out(cs_n), .sclk_out(sclk),
    .sdi_out(sdi));
  acrc_ctrl dut (.CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce), .CS_N_IN(cs_n), .SCLK_IN(sclk),
    .SDI_IN(sdi), .SDO_OUT(sdo), .SDO_OE_OUT(soe), .SAMPLE_IN(smp), .SAMPLE_VALID_IN(smp_v),
    .DATA_OUT(dout), .DATA_VALID_OUT(dv), .CHANNEL_SEL_OUT(chs), .OCLK_P_OUT(ocp),
    .OCLK_N_OUT(ocn), .OCLK_OE_OUT(oce));
  task chk(input [39:0] nm, input [11:0] e, input [11:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("Error %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [12:0] a, input [7:0] v);
    host.xfer({3'h0, a, v}, q);
  endtask
  task rd(input [12:0] a, input [7:0] e);
    begin
      host.xfer({3'h4, a, 8'h00}, q);
      chk("read", e, q);
    end
  endtask
  task sample(input [11:0] x, input [11:0] e, input [2:0] c);
    begin
      @(posedge clk);
      smp <= x;
      smp_v <= 1'b1;
      @(posedge clk);
      smp_v <= 1'b0;
      #1;
      chk("valid", 12'h001, dv);
      chk("data", e, dout);
      chk("chan", c, chs);
    end
  endtask
  task complete_run;
    begin
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    err_count = err_count + 1;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(13'h001, 8'h4f);
    rd(13'h002, 8'h00);
    rd(13'h003, 8'h00);
    for (i = 1; i < 9; i = i + 1) begin
      wr(13'h001, {2'b01, i[2:0], 3'h7});
      for (k = 1; k <= i; k = k + 1)
        sample(12'h100 + k, 12'h100 + k, k % i);
    end
    // sample offered while frozen must be ignored
    @(posedge clk);
    ce <= 1'b0;
    smp <= 12'h3c5;
    smp_v <= 1'b1;
    @(posedge clk);
    smp_v <= 1'b0;
    #1;
    chk("frzv", 12'h000, dv);
    chk("frzc", 12'h000, chs);
    @(posedge clk);
    ce <= 1'b1;
    sample(12'h155, 12'h155, 3'h1);
    wr(13'h002, 8'h5a);
    rd(13'h002, 8'h5a);
    chk("oclk", 12'h001, oce);
    wr(13'h001, 8'hcf);
    for (i = 0; i < 16; i = i + 1) begin
      wr(13'h002, {4'h0, i[3:0]});
      chk("oclk", (i < 10 || i > 14), oce);
    end
    wr(13'h001, 8'h4f);
    for (i = 0; i < 4; i = i + 1) begin
      d = i ? 4'hc + i : 4'h0;
      wr(13'h002, {d, 4'h0});
      chk("oclk", (i == 0 || i == 3), oce);
      sample(12'h7e1, i ? 12'h000 : 12'h7e1, 3'h0);
    end
    // mid-run reset brings written registers back to their reset values
    wr(13'h001, 8'hcf);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(13'h001, 8'h4f);
    rd(13'h002, 8'h00);
    complete_run;
  end
endmodule
